// >>> common/isabc_pkg.sv
// isabc_pkg: constants and carriers for the isa system bus controller
package isabc_pkg;
  // -------------------------------------------------
  // register indexes
  // -------------------------------------------------
  localparam logic [7:0] IDX_ROM_CFG_A   = 8'h16;
  localparam logic [7:0] IDX_ROM_CFG_B   = 8'h17;
  localparam logic [7:0] IDX_MISC_STAT   = 8'h1f;
  localparam logic [7:0] IDX_BUS_SPEED   = 8'h22;
  localparam logic [7:0] IDX_PERIPH_ROUT = 8'h24;
  localparam logic [7:0] REG_RST         = 8'h00;
  // -------------------------------------------------
  // field positions
  // -------------------------------------------------
  localparam int SPD_DIV_MSB    = 2;
  localparam int SPD_TD_EN      = 7;
  localparam int ROMA_SYS_EN    = 0;
  localparam int ROMA_VID_EN    = 1;
  localparam int ROMB_SMM_EN    = 7;
  localparam int ROMB_WR_SD     = 4;
  localparam int ROMB_WS_MSB    = 3;
  localparam int ROUT_RTC_SD    = 0;
  localparam int ROUT_KBD_SD    = 1;
  localparam int MISC_ROM8      = 2;
  // -------------------------------------------------
  // addresses and timing
  // -------------------------------------------------
  localparam logic [23:0] ROM_RESET_ADDR = 24'hfffff0;
  localparam logic [6:0]  ROM_SYS_BLK    = 7'h07;
  localparam logic [6:0]  ROM_SYS_ALIAS  = 7'h7f;
  localparam logic [5:0]  ROM_VID_BLK    = 6'h06;
  localparam logic [15:0] IO_SD_BASE     = 16'h0100;
  localparam logic [15:0] IO_RTC_INDEX   = 16'h0070;
  localparam logic [15:0] IO_RTC_DATA    = 16'h0071;
  localparam logic [15:0] IO_KBD_DATA    = 16'h0060;
  localparam logic [15:0] IO_KBD_CMD     = 16'h0064;
  localparam logic [7:0]  FLOAT_BYTE     = 8'hff;
  localparam logic [3:0]  IO_WAIT_TICKS  = 4'h4;
  // -------------------------------------------------
  // types
  // -------------------------------------------------
  typedef struct packed {
    logic [23:0] addr;
    logic        io;
    logic        wr;
    logic [1:0]  be_n;
    logic [15:0] wdata;
    logic        hit_sysmem;
    logic        hit_npu;
    logic        hit_local;
    logic        hit_internal;
  } isabc_req_s;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_CMD  = 5'b00010,
    ST_NEXT = 5'b00100,
    ST_DONE = 5'b01000,
    ST_GAP  = 5'b10000
  } isabc_state_e;
endpackage : isabc_pkg

// >>> core/isabc_top.sv
// isabc_top: isa system bus controller core
//
// How it works
// - bus clock divides cpu clock per speed
// - force non-pipelined cpu during bus cycle
// - address buffer direction from hlda, master
// - sa0 from byte enables, dma, master input
// - byte steering; split 16-bit to 8-bit
// - latch read data, return with ready
// - unclaimed cpu cycles go to bus
// - translator disable low unless bit7 set
// - io 100h up and memory on expansion
// - routing register places rtc and keyboard
// - rom select on enabled rom reads
// - two config registers enable rom ranges
// - config b sets waits, rom write bus
// - power-on assumes 16-bit boot rom
// - first reset read high byte checked
// - ff high byte: rerun as 8-bit
// - rom width in misc status bit2
// - clock chip index, read, write strobes
// - invert clock chip interrupt to irq8
// - keyboard select at 060h, 064h
// - keyboard reset, address bit20 gate
`timescale 1ns/100ps
module isabc_top
  import isabc_pkg::*;
#(
  parameter int SYN_W = 7
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       req_valid,
  input  wire isabc_req_s req,
  output logic            cpu_ready,
  output logic [15:0]     cpu_rdata,
  output logic            cpu_nonpipe,
  input  wire logic       hlda,
  input  wire logic       dma_sa0,
  input  wire logic       cpu_a20_in,
  output logic            cpu_a20_out,
  output logic            cpu_reset,
  input  wire logic [SYN_W-1:0] pins_in,
  output logic            sysclk,
  output logic            address_buffer_direction_n,
  input  wire logic       sa0_in,
  output logic            sa0_out,
  output logic            sa0_oe,
  input  wire logic [15:0] peripheral_data_bus_in,
  output logic [15:0]     peripheral_data_bus_out,
  output logic            peripheral_data_bus_oe,
  output logic            translator_disable_n,
  output logic            low_lane_direction,
  output logic            high_lane_direction,
  output logic            ior_n,
  output logic            iow_n,
  output logic            memr_n,
  output logic            memw_n,
  output logic            boot_rom_select_n,
  output logic            clock_chip_index_strobe,
  output logic            clock_chip_read_strobe_n,
  output logic            clock_chip_write_strobe_n,
  output logic            irq8,
  output logic            keyboard_ctrl_select_n,
  input  wire logic [7:0] reg_index,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata
);
  // -------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------
  // pins_in: 6 memcs16_n 5 iocs16_n 4 local_bus_claim_n 3 address_line20_gate
  //          2 keyboard_reset_request_n 1 irq8_n 0 master_n
  wire [SYN_W-1:0] pin_sync;
  genvar gi;
  generate
    for (gi = 0; gi < SYN_W; gi++)
    begin : g_sync
      logic s1_reg, s2_reg, s3_reg, q_reg;
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          s1_reg <= 1'b1;
          s2_reg <= 1'b1;
          s3_reg <= 1'b1;
          q_reg  <= 1'b1;
        end
        else
        begin
          s1_reg <= pins_in[gi];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg)
            q_reg <= s3_reg;
        end
      end
      // one process per bit, so no vector has two writers
      assign pin_sync[gi] = q_reg;
    end
  endgenerate
  wire master_n  = pin_sync[0];
  wire irq8_n    = pin_sync[1];
  wire kbrst_n   = pin_sync[2];
  wire a20_gate  = pin_sync[3];
  wire claim_n   = pin_sync[4];
  wire iocs16_n  = pin_sync[5];
  wire memcs16_n = pin_sync[6];
  // -------------------------------------------------
  // registers
  // -------------------------------------------------
  logic [7:0] rom_a_reg, rom_b_reg, speed_reg, rout_reg;
  logic       rom8_reg, detect_done_reg;
  wire [7:0]  misc_status = {5'h00, rom8_reg, 2'h0};
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rom_a_reg <= REG_RST;
      rom_b_reg <= REG_RST;
      speed_reg <= REG_RST;
      rout_reg  <= REG_RST;
    end
    else if (reg_wr)
    begin
      if (reg_index == IDX_ROM_CFG_A)   rom_a_reg <= reg_wdata;
      if (reg_index == IDX_ROM_CFG_B)   rom_b_reg <= reg_wdata;
      if (reg_index == IDX_BUS_SPEED)   speed_reg <= reg_wdata;
      if (reg_index == IDX_PERIPH_ROUT) rout_reg  <= reg_wdata;
    end
  end
  wire [7:0] rd_mux = (reg_index == IDX_ROM_CFG_A)   ? rom_a_reg :
                      (reg_index == IDX_ROM_CFG_B)   ? rom_b_reg :
                      (reg_index == IDX_MISC_STAT)   ? misc_status :
                      (reg_index == IDX_BUS_SPEED)   ? speed_reg :
                      (reg_index == IDX_PERIPH_ROUT) ? rout_reg : 8'h00;
  // -------------------------------------------------
  // bus clock divider
  // -------------------------------------------------
  logic [3:0] div_reg;
  logic       sysclk_reg;
  wire div_hit  = div_reg >= {1'b0, speed_reg[SPD_DIV_MSB:0]};
  wire bus_tick = div_hit & ~sysclk_reg;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      div_reg    <= 4'h0;
      sysclk_reg <= 1'b0;
    end
    else if (div_hit)
    begin
      div_reg    <= 4'h0;
      sysclk_reg <= ~sysclk_reg;
    end
    else
      div_reg <= div_reg + 4'h1;
  end
  // -------------------------------------------------
  // cycle decode
  // -------------------------------------------------
  wire [23:0] a = req.addr;
  wire in_sys = (a[23:17] == ROM_SYS_BLK) | (a[23:17] == ROM_SYS_ALIAS);
  wire in_vid = a[23:17] == {1'b0, ROM_VID_BLK};
  wire rom_rng = (in_sys & (rom_a_reg[ROMA_SYS_EN] | rom_b_reg[ROMB_SMM_EN])) |
                 (in_vid & rom_a_reg[ROMA_VID_EN]);
  wire rom_rd  = ~req.io & ~req.wr & rom_rng;
  wire is_rtc  = req.io & ((a[15:0] == IO_RTC_INDEX) | (a[15:0] == IO_RTC_DATA));
  wire is_kbd  = req.io & ((a[15:0] == IO_KBD_DATA) | (a[15:0] == IO_KBD_CMD));
  wire io_sd   = (a[15:0] >= IO_SD_BASE) | (is_rtc & rout_reg[ROUT_RTC_SD]) |
                 (is_kbd & rout_reg[ROUT_KBD_SD]);
  wire mem_sd  = ~rom_rng | (req.wr & rom_b_reg[ROMB_WR_SD]);
  wire on_sd   = (req.io ? io_sd : mem_sd) & claim_n;
  wire to_bus  = req_valid & ~(req.hit_sysmem | req.hit_npu | req.hit_local |
                               req.hit_internal);
  wire narrow  = rom_rd ? rom8_reg : (req.io ? iocs16_n : memcs16_n);
  wire both_b  = ~req.be_n[0] & ~req.be_n[1];
  wire [3:0] ws_load = rom_rd ? rom_b_reg[ROMB_WS_MSB:0] : IO_WAIT_TICKS;
  // -------------------------------------------------
  // cycle sequencer
  // -------------------------------------------------
  isabc_state_e st_reg;
  isabc_req_s   cur_reg;
  logic         split_reg, hi_reg, narrow_reg, rom_reg, sd_reg;
  logic [3:0]   wcnt_reg;
  logic [15:0]  rdat_reg;
  wire at_reset_addr = cur_reg.addr == ROM_RESET_ADDR;
  wire detect_now = rom_reg & ~cur_reg.wr & at_reset_addr & ~detect_done_reg & ~split_reg;
  wire floated = peripheral_data_bus_in[15:8] == FLOAT_BYTE;
  // strobes reach the pins a cycle late: never sample before they are out
  wire cmd_live   = ~(ior_n & iow_n & memr_n & memw_n);
  wire strobe_end = (st_reg == ST_CMD) & bus_tick & cmd_live & (wcnt_reg == 4'h0);
  wire lane_lo = narrow_reg | ~hi_reg;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_reg          <= ST_IDLE;
      cur_reg         <= '0;
      split_reg       <= 1'b0;
      hi_reg          <= 1'b0;
      narrow_reg      <= 1'b0;
      rom_reg         <= 1'b0;
      sd_reg          <= 1'b0;
      wcnt_reg        <= 4'h0;
      rdat_reg        <= 16'h0000;
      rom8_reg        <= 1'b0;
      detect_done_reg <= 1'b0;
    end
    else
    begin
      case (st_reg)
        ST_IDLE:
          if (to_bus)
          begin
            cur_reg    <= req;
            split_reg  <= both_b & narrow;
            hi_reg     <= req.be_n[0];
            narrow_reg <= narrow;
            rom_reg    <= rom_rd;
            sd_reg     <= on_sd;
            wcnt_reg   <= ws_load;
            st_reg     <= ST_CMD;
          end
        ST_CMD:
          if (bus_tick & cmd_live)
          begin
            if (wcnt_reg != 4'h0)
              wcnt_reg <= wcnt_reg - 4'h1;
            else
            begin
              if (~narrow_reg)
                rdat_reg <= peripheral_data_bus_in;
              else if (hi_reg)
                rdat_reg[15:8] <= peripheral_data_bus_in[7:0];
              else
                rdat_reg[7:0] <= peripheral_data_bus_in[7:0];
              if (detect_now)
              begin
                detect_done_reg <= 1'b1;
                if (floated)
                begin
                  rom8_reg   <= 1'b1;
                  narrow_reg <= 1'b1;
                  split_reg  <= 1'b1;
                  hi_reg     <= 1'b1; // next flips it: even byte first
                  st_reg     <= ST_NEXT;
                end
                else
                  st_reg <= ST_DONE;
              end
              else if (split_reg & ~hi_reg)
                st_reg <= ST_NEXT;
              else
                st_reg <= ST_DONE;
            end
          end
        ST_NEXT:
          if (bus_tick)
          begin
            hi_reg   <= ~hi_reg | (split_reg & rom8_reg & ~hi_reg);
            wcnt_reg <= rom_reg ? rom_b_reg[ROMB_WS_MSB:0] : IO_WAIT_TICKS;
            st_reg   <= ST_CMD;
          end
        ST_DONE:
          st_reg <= ST_GAP;
        ST_GAP:
          st_reg <= ST_IDLE;
        default:
          st_reg <= ST_IDLE;
      endcase
    end
  end
  // -------------------------------------------------
  // registered outputs
  // -------------------------------------------------
  wire busy  = st_reg != ST_IDLE;
  wire cmd   = st_reg == ST_CMD;
  wire c_io  = cur_reg.io;
  wire c_wr  = cur_reg.wr;
  wire [15:0] c_a = cur_reg.addr[15:0];
  wire [15:0] wout = lane_lo ? {cur_reg.wdata[15:8], hi_reg ? cur_reg.wdata[15:8] :
                                cur_reg.wdata[7:0]} : cur_reg.wdata;
  // a master owns the bus when hlda is high and master_n low: buffers face the card
  wire master_own = hlda & ~master_n;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cpu_ready                  <= 1'b0;
      cpu_rdata                  <= 16'h0000;
      cpu_nonpipe                <= 1'b0;
      cpu_a20_out                <= 1'b0;
      cpu_reset                  <= 1'b1;
      sysclk                     <= 1'b0;
      address_buffer_direction_n <= 1'b1;
      sa0_out                    <= 1'b0;
      sa0_oe                     <= 1'b1;
      peripheral_data_bus_out    <= 16'h0000;
      peripheral_data_bus_oe     <= 1'b0;
      translator_disable_n       <= 1'b0;
      low_lane_direction         <= 1'b0;
      high_lane_direction        <= 1'b0;
      ior_n                      <= 1'b1;
      iow_n                      <= 1'b1;
      memr_n                     <= 1'b1;
      memw_n                     <= 1'b1;
      boot_rom_select_n          <= 1'b1;
      clock_chip_index_strobe    <= 1'b0;
      clock_chip_read_strobe_n   <= 1'b1;
      clock_chip_write_strobe_n  <= 1'b1;
      irq8                       <= 1'b0;
      keyboard_ctrl_select_n     <= 1'b1;
      reg_rdata                  <= 8'h00;
    end
    else
    begin
      cpu_ready   <= st_reg == ST_DONE;
      cpu_rdata   <= rdat_reg;
      cpu_nonpipe <= busy;
      cpu_a20_out <= cpu_a20_in & a20_gate;
      cpu_reset   <= ~kbrst_n;
      sysclk      <= sysclk_reg;
      address_buffer_direction_n <= ~master_own;
      sa0_oe      <= ~master_own;
      sa0_out     <= hlda ? dma_sa0 : hi_reg;
      peripheral_data_bus_out <= wout;
      peripheral_data_bus_oe  <= cmd & c_wr & ~sd_reg;
      translator_disable_n    <= speed_reg[SPD_TD_EN] & ~(busy & sd_reg);
      low_lane_direction      <= busy & ~c_wr;
      high_lane_direction     <= busy & ~c_wr & ~lane_lo;
      ior_n  <= ~(cmd & c_io & ~c_wr);
      iow_n  <= ~(cmd & c_io & c_wr);
      memr_n <= ~(cmd & ~c_io & ~c_wr);
      memw_n <= ~(cmd & ~c_io & c_wr);
      boot_rom_select_n <= ~(cmd & rom_reg);
      clock_chip_index_strobe   <= cmd & c_io & c_wr & (c_a == IO_RTC_INDEX);
      clock_chip_read_strobe_n  <= ~(cmd & c_io & ~c_wr & (c_a == IO_RTC_DATA));
      clock_chip_write_strobe_n <= ~(cmd & c_io & c_wr & (c_a == IO_RTC_DATA));
      irq8 <= ~irq8_n;
      keyboard_ctrl_select_n <= ~(cmd & c_io & ((c_a == IO_KBD_DATA) |
                                               (c_a == IO_KBD_CMD)));
      reg_rdata <= rd_mux;
    end
  end
  // -------------------------------------------------
  // assertions
  // -------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_nonpipe_busy: assert property (busy |=> cpu_nonpipe)
    else $error("nonpipe not forced during bus cycle");
  a_td_off: assert property (!speed_reg[SPD_TD_EN] |=> !translator_disable_n)
    else $error("translator disable high while function off");
  a_dir_master: assert property (master_own |=> !address_buffer_direction_n && !sa0_oe)
    else $error("buffer direction wrong under master");
  a_rom8_sticky: assert property (rom8_reg |=> rom8_reg)
    else $error("8-bit rom mode lost");
  a_misc_width: assert property (reg_index == IDX_MISC_STAT
    |=> reg_rdata[MISC_ROM8] == $past(rom8_reg))
    else $error("status width bit mismatch");
  a_detect_float: assert property (strobe_end && detect_now && floated
    |=> rom8_reg && st_reg == ST_NEXT)
    else $error("floated rom byte not rerun");
  a_detect_keep: assert property (strobe_end && detect_now && !floated
    |=> !rom8_reg ##1 cpu_ready)
    else $error("16-bit rom read not completed");
  a_split_two: assert property (st_reg == ST_CMD && split_reg && !hi_reg && strobe_end
    |=> st_reg == ST_NEXT)
    else $error("split cycle missing second byte");
  a_irq8_inv: assert property ($fell(irq8_n) |=> irq8)
    else $error("irq8 not inverted");
  a_route_take: assert property (st_reg == ST_IDLE && to_bus |=> st_reg == ST_CMD)
    else $error("unclaimed cycle not taken");
  c_split_run: cover property (split_reg && cpu_ready);
  c_rom8_enter: cover property ($rose(rom8_reg));
  c_rtc_write: cover property (!clock_chip_write_strobe_n);
endmodule : isabc_top

// >>> tb/isabc_periph_model.sv
// isabc_periph_model: far-side peripherals and boot rom on the peripheral data bus
`timescale 1ns/100ps
module isabc_periph_model (
  input  wire logic        ior_n,
  input  wire logic        memr_n,
  input  wire logic        boot_rom_select_n,
  input  wire logic        sa0_out,
  input  wire logic        rom_narrow,
  output logic [15:0]      data
);
  // -------------------------------------------------
  // read response
  // -------------------------------------------------
  logic [15:0] last_q = 16'h0000;
  logic [15:0] val;
  always @*
  begin
    // narrow rom leaves the high lane to its pull-up, hence ff
    if (!boot_rom_select_n && !memr_n)
      val = rom_narrow ? {8'hff, sa0_out ? 8'hb2 : 8'ha1} : 16'h5aea;
    else
      val = {8'h7e, sa0_out ? 8'h5c : 8'h4b};
    if (!ior_n || (!memr_n && !boot_rom_select_n))
    begin
      data = val;
      last_q = val;
    end
    else
      data = ~last_q; // released: stale value must not survive
  end
endmodule : isabc_periph_model

// >>> tb/test_isa_system_bus_controller.sv
// test_isa_system_bus_controller: self-checking bench for the bus controller
`timescale 1ns/100ps
module test_isa_system_bus_controller;
  import isabc_pkg::*;
  // -------------------------------------------------
  // signals
  // -------------------------------------------------
  logic clk = 0, rst = 1, req_valid = 0, hlda = 0, reg_wr = 0, rom_narrow = 0;
  isabc_req_s req = '0;
  logic [6:0] pins = 7'h7f; // claim pin idle
  logic [7:0] reg_index = 8'h00, reg_wdata = 8'h00, reg_rdata, r;
  logic [15:0] pdata, d, cpu_rdata;
  logic cpu_ready, cpu_a20_out, cpu_reset, sysclk, abd_n, sa0_out, sa0_oe, td_n;
  logic ior_n, memr_n, rom_n, as_s, rd_n, wr_n, irq8, kbd_n, ior_q, memr_q;
  logic [6:0] seen;
  int n_errors = 0, n_compared = 0, n_cmd, i, k;
  logic [7:0] idx [5] = '{8'h16, 8'h17, 8'h22, 8'h24, 8'h1f};
  logic [15:0] ioa [5] = '{16'h70, 16'h71, 16'h71, 16'h60, 16'h64};
  logic iow [5] = '{1, 0, 1, 0, 1};
  int sel [5] = '{0, 1, 2, 3, 3};
  always #2.5 clk = ~clk;
  isabc_top dut (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req),
    .cpu_ready(cpu_ready), .cpu_rdata(cpu_rdata), .cpu_nonpipe(), .hlda(hlda),
    .dma_sa0(1'b0), .cpu_a20_in(1'b1), .cpu_a20_out(cpu_a20_out), .cpu_reset(cpu_reset),
    .pins_in(pins), .sysclk(sysclk), .address_buffer_direction_n(abd_n), .sa0_in(1'b0),
    .sa0_out(sa0_out), .sa0_oe(sa0_oe), .peripheral_data_bus_in(pdata),
    .peripheral_data_bus_out(), .peripheral_data_bus_oe(), .translator_disable_n(td_n),
    .low_lane_direction(), .high_lane_direction(), .ior_n(ior_n), .iow_n(),
    .memr_n(memr_n), .memw_n(), .boot_rom_select_n(rom_n), .clock_chip_index_strobe(as_s),
    .clock_chip_read_strobe_n(rd_n), .clock_chip_write_strobe_n(wr_n), .irq8(irq8),
    .keyboard_ctrl_select_n(kbd_n), .reg_index(reg_index), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  isabc_periph_model far (.ior_n(ior_n), .memr_n(memr_n), .boot_rom_select_n(rom_n),
    .sa0_out(sa0_out), .rom_narrow(rom_narrow), .data(pdata));
  // sticky strobe history, cleared at each cycle start
  always @(posedge clk)
  begin
    seen <= seen | {!td_n, td_n, !rom_n, !kbd_n, !wr_n, !rd_n, as_s};
    if ((!ior_n && ior_q) || (!memr_n && memr_q)) n_cmd <= n_cmd + 1;
    ior_q <= ior_n;
    memr_q <= memr_n;
  end
  // -------------------------------------------------
  // tasks
  // -------------------------------------------------
  task automatic end_of_test;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test
  task automatic chk_data(input logic [15:0] g, input logic [15:0] e, input string m);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk_data
  task automatic chk_flag(input logic g, input logic e, input string m);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %0t %s got %b exp %b", $time, m, g, e);
    end
  endtask : chk_flag
  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk); #1;
    reg_index = a; reg_wdata = v; reg_wr = 1;
    @(posedge clk); #1;
    reg_wr = 0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk); #1;
    reg_index = a;
    @(posedge clk); #1;
    v = reg_rdata;
  endtask : rreg
  task automatic cyc(input logic [23:0] a, input logic io, input logic wr,
                     input logic [1:0] be, input logic h, output logic [15:0] v);
    int lim;
    lim = h ? 60 : 2000; // a claimed cycle must never finish here
    @(posedge clk); #1;
    seen = '0; n_cmd = 0;
    req = '0; req.addr = a; req.io = io; req.wr = wr; req.be_n = be;
    req.wdata = 16'h3c96; req.hit_sysmem = h; req_valid = 1;
    @(posedge clk); #1;
    req_valid = 0;
    for (i = 0; i < lim && cpu_ready !== 1'b1; i++) begin @(posedge clk); #1; end
    v = cpu_rdata;
    if (!h && i >= lim)
    begin
      n_errors++;
      $display("ERROR %0t bus cycle never finished", $time);
      end_of_test();
    end
    repeat (2) @(posedge clk);
    #1;
  endtask : cyc
  task automatic do_reset;
    rst = 1;
    repeat (2) @(posedge clk);
    #1 rst = 0;
    repeat (8) @(posedge clk); // synchronisers need time to settle
    #1;
  endtask : do_reset
  // -------------------------------------------------
  // sequence
  // -------------------------------------------------
  initial
  begin
    do_reset();
    for (k = 0; k < 5; k++)
    begin
      rreg(idx[k], r); chk_data({8'h00, r}, 16'h0000, "reg reset");
      wreg(idx[k], 8'ha5); rreg(idx[k], r);
      chk_data({8'h00, r}, (k == 4) ? 16'h0000 : 16'h00a5, "reg rw");
      wreg(idx[k], 8'h00);
    end
    wreg(8'h30, 8'h55); rreg(8'h30, r); chk_data({8'h00, r}, 16'h0000, "unmapped");
    $display("test registers done");
    wreg(IDX_BUS_SPEED, 8'h02);
    for (i = 0; i < 50 && sysclk !== 1'b0; i++) begin @(posedge clk); #1; end
    for (i = 0; i < 50 && sysclk !== 1'b1; i++) begin @(posedge clk); #1; end
    for (k = 0; k < 50 && sysclk === 1'b1; k++) begin @(posedge clk); #1; end
    chk_data(16'(k), 16'd3, "bus clock half period");
    wreg(IDX_BUS_SPEED, 8'h00);
    $display("test bus clock done");
    for (k = 0; k < 5; k++)
    begin
      cyc({8'h00, ioa[k]}, 1, iow[k], 2'b00, 0, d);
      chk_data({12'h000, seen[3:0]}, 16'(1 << sel[k]), "chip strobes");
      chk_flag(seen[5], 0, "translator disable idle");
    end
    $display("test strobes done");
    cyc(24'h000300, 1, 0, 2'b00, 0, d);
    chk_data(d, 16'h5c4b, "split read data");
    chk_data(16'(n_cmd), 16'd2, "split command count");
    pins[5] = 0;
    repeat (8) @(posedge clk);
    cyc(24'h000300, 1, 0, 2'b00, 0, d);
    chk_data(d, 16'h7e4b, "wide read data");
    chk_data(16'(n_cmd), 16'd1, "wide command count");
    pins[5] = 1;
    cyc(24'h000300, 1, 0, 2'b00, 1, d);
    chk_data(16'(n_cmd), 16'd0, "claimed cycle ignored");
    wreg(IDX_BUS_SPEED, 8'h80);
    cyc(24'h000070, 1, 1, 2'b00, 0, d);
    chk_flag(seen[5], 1, "translator disable on");
    chk_flag(seen[6], 0, "peripheral cycle keeps disable");
    cyc(24'h000300, 1, 0, 2'b00, 0, d);
    chk_flag(seen[6], 1, "expansion cycle enables");
    wreg(IDX_PERIPH_ROUT, 8'h01);
    cyc(24'h000070, 1, 1, 2'b00, 0, d);
    chk_flag(seen[6], 1, "rtc routed to expansion");
    wreg(IDX_PERIPH_ROUT, 8'h00);
    pins[4] = 0; // device claims its cycle
    repeat (8) @(posedge clk);
    cyc(24'h000300, 1, 0, 2'b00, 0, d);
    chk_flag(seen[6], 0, "claimed by peripheral bus");
    pins[4] = 1;
    wreg(IDX_BUS_SPEED, 8'h00);
    $display("test steering done");
    wreg(IDX_ROM_CFG_A, 8'h01); rom_narrow = 1;
    for (k = 0; k < 2; k++)
    begin
      cyc(ROM_RESET_ADDR, 0, 0, 2'b00, 0, d);
      chk_data(d, 16'hb2a1, "narrow rom word");
      chk_flag(seen[4], 1, "rom select");
    end
    chk_data(16'(n_cmd), 16'd2, "sticky narrow mode");
    rreg(IDX_MISC_STAT, r); chk_flag(r[2], 1, "rom width narrow");
    do_reset();
    rreg(IDX_MISC_STAT, r); chk_flag(r[2], 0, "rom width after reset");
    rom_narrow = 0; wreg(IDX_ROM_CFG_A, 8'h01);
    cyc(ROM_RESET_ADDR, 0, 0, 2'b00, 0, d);
    chk_data(d, 16'h5aea, "wide rom word");
    rreg(IDX_MISC_STAT, r); chk_flag(r[2], 0, "rom width wide");
    wreg(IDX_ROM_CFG_A, 8'h02);
    cyc(24'h0c0000, 0, 0, 2'b00, 0, d);
    chk_flag(seen[4], 1, "video range select");
    wreg(IDX_ROM_CFG_A, 8'h00);
    cyc(24'h0e0000, 0, 0, 2'b00, 0, d);
    chk_flag(seen[4], 0, "disabled range");
    $display("test rom done");
    pins = 7'h70; hlda = 1; // master owns the bus, pins asserted
    repeat (10) @(posedge clk); #1;
    chk_flag(irq8, 1, "clock chip interrupt");
    chk_flag(cpu_reset, 1, "keyboard reset");
    chk_flag(cpu_a20_out, 0, "a20 masked");
    chk_flag(abd_n, 0, "buffer direction");
    chk_flag(sa0_oe, 0, "sa0 released");
    $display("test pins done");
    end_of_test();
  end
endmodule : test_isa_system_bus_controller
